// *** rtl/flash_command_behavior_config.sv ***
// Command behaviour configuration bank with stored and active copies.
module flash_command_behavior_config
(
	input  wire logic                              clk,
	input  wire logic                              rst_n,
	input  wire logic                              clk_en,
	input  wire logic                              reload,
	input  wire logic                              req_valid,
	input  wire behavior_cfg_pkg::reg_req_s        req,
	output logic      [7:0]                        read_data,
	input  wire logic                              opcode_valid,
	input  wire logic [7:0]                        opcode,
	input  wire logic                              erase_req,
	input  wire logic                              sector_erase_ok,
	input  wire logic                              zero_found,
	input  wire logic                              blank_read_done,
	output behavior_cfg_pkg::erase_action_e        erase_action,
	output logic                                   erase_start,
	output logic                                   erase_skip,
	output logic      [8:0]                        page_wrap_mask,
	output behavior_cfg_pkg::controls_s            controls,
	output logic                                   opcode_is_resume,
	output logic                                   opcode_is_clear_status,
	output logic                                   soft_reset
);

	// ------------------------------------------------------------
	// Storage
	// ------------------------------------------------------------
	logic [7:0] behavior_cfg_stored;
	logic [7:0] behavior_cfg_active;
	logic       stored_loaded;
	logic       reset_armed;
	logic       next_reset_armed;

	wire        wr_stored = clk_en & req_valid & req.write & (req.sel == behavior_cfg_pkg::SEL_STORED);
	wire        wr_active = clk_en & req_valid & req.write & (req.sel == behavior_cfg_pkg::SEL_ACTIVE);
	// Once-only flip: every defined bit takes the written value, whatever it held, but only on the first write.
	wire [7:0]  flip_mask = stored_loaded ? 8'h00 : behavior_cfg_pkg::DEFINED_MASK;
	wire [7:0]  next_stored = (behavior_cfg_stored & ~flip_mask) | (req.data & flip_mask);
	// Host may not touch the sector-layout bit nor the reserved bits.
	wire [7:0]  wr_mask = behavior_cfg_pkg::DEFINED_MASK & ~behavior_cfg_pkg::ACTIVE_RO_MASK;
	wire [7:0]  next_active = (behavior_cfg_active & ~wr_mask) | (req.data & wr_mask);

	wire        is_reset_op   = opcode_valid & clk_en;
	wire        legacy_reset  = is_reset_op & (opcode == behavior_cfg_pkg::OP_LEGACY_RST)
	                            & behavior_cfg_active[behavior_cfg_pkg::BIT_LEGACY_RST];
	wire        pair_reset    = is_reset_op & reset_armed
	                            & (opcode == behavior_cfg_pkg::OP_RST_EXECUTE);
	wire        do_reload     = (reload & clk_en) | legacy_reset | pair_reset;

	assign next_reset_armed = opcode_valid ? (opcode == behavior_cfg_pkg::OP_RST_ENABLE) : reset_armed;

	// ------------------------------------------------------------
	// Stored copy, one-time flip
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			behavior_cfg_stored <= behavior_cfg_pkg::STORED_SHIPPED;
			stored_loaded       <= 1'b0;
		end
		else if (wr_stored)
		begin
			behavior_cfg_stored <= next_stored;
			stored_loaded       <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// Active copy and two-step reset tracking
	// ------------------------------------------------------------
	// Reset leaves the active copy at the shipped value; only reload or a soft reset loads it from storage.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			behavior_cfg_active <= behavior_cfg_pkg::STORED_SHIPPED;
		else if (do_reload)
			behavior_cfg_active <= behavior_cfg_stored & behavior_cfg_pkg::DEFINED_MASK;
		else if (wr_active)
			behavior_cfg_active <= next_active;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			reset_armed <= 1'b0;
		else if (clk_en)
			reset_armed <= next_reset_armed;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			read_data <= 8'h00;
		else if (clk_en && req_valid && !req.write)
			read_data <= (req.sel == behavior_cfg_pkg::SEL_ACTIVE) ? behavior_cfg_active
			                                                      : behavior_cfg_stored;
	end

	// ------------------------------------------------------------
	// Controls seen by the command and erase engines
	// ------------------------------------------------------------
	// The block size bit has no consumer: this density always erases one uniform sector.
	assign controls.blank_check          = behavior_cfg_active[behavior_cfg_pkg::BIT_BLANK_CHECK];
	assign controls.page_wrap            = behavior_cfg_active[behavior_cfg_pkg::BIT_PAGE_WRAP];
	assign controls.param_sector_disable = behavior_cfg_active[behavior_cfg_pkg::BIT_PARAM_DIS];
	assign controls.resume_select        = behavior_cfg_active[behavior_cfg_pkg::BIT_RESUME_SEL];
	assign controls.legacy_reset_enable  = behavior_cfg_active[behavior_cfg_pkg::BIT_LEGACY_RST];

	assign page_wrap_mask = controls.page_wrap ? behavior_cfg_pkg::WRAP_LONG_MASK
	                                           : behavior_cfg_pkg::WRAP_SHORT_MASK;

	wire   op_30 = opcode_valid & (opcode == behavior_cfg_pkg::OP_RESUME_CLR);
	assign opcode_is_resume       = op_30 & controls.resume_select;
	assign opcode_is_clear_status = op_30 & ~controls.resume_select;
	assign soft_reset             = legacy_reset | pair_reset;

	// Erase decision for parameter, sector and bulk erase alike.
	assign erase_action = !controls.blank_check ? behavior_cfg_pkg::ERASE_DIRECT
	                    : !sector_erase_ok      ? behavior_cfg_pkg::ERASE_DIRECT
	                    :                         behavior_cfg_pkg::ERASE_BLANK_READ;
	assign erase_start  = erase_req & ((erase_action == behavior_cfg_pkg::ERASE_DIRECT)
	                    | zero_found);
	assign erase_skip   = erase_req & (erase_action == behavior_cfg_pkg::ERASE_BLANK_READ)
	                    & blank_read_done & ~zero_found;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	sequence active_written_s;
		clk_en && req_valid && req.write && req.sel == behavior_cfg_pkg::SEL_ACTIVE
		&& !do_reload;
	endsequence

	active_write_a: assert property (@(posedge clk) disable iff (!rst_n)
		active_written_s |=> behavior_cfg_active[5:4] == $past(req.data[5:4]))
		else $error("Active write not applied.");

	reload_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
		do_reload |=> behavior_cfg_active == ($past(behavior_cfg_stored) & 8'h3F))
		else $error("Reload did not copy stored value.");

	sector_ro_a: assert property (@(posedge clk) disable iff (!rst_n)
		!$past(do_reload) |-> $stable(behavior_cfg_active[3]))
		else $error("Sector bit changed without reload.");

	once_only_a: assert property (@(posedge clk) disable iff (!rst_n)
		$past(stored_loaded) |-> $stable(behavior_cfg_stored))
		else $error("Stored copy changed twice.");

	reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
		behavior_cfg_active[7:6] == 2'b00 && behavior_cfg_stored[7:6] == 2'b00)
		else $error("Reserved bits not zero.");

	wrap_point_a: assert property (@(posedge clk) disable iff (!rst_n)
		page_wrap_mask[8] == behavior_cfg_active[4])
		else $error("Wrap point wrong.");

	op30_decode_a: assert property (@(posedge clk) disable iff (!rst_n)
		op_30 |-> opcode_is_resume == behavior_cfg_active[2] && opcode_is_clear_status != behavior_cfg_active[2])
		else $error("Opcode 30 decoded wrongly.");

	legacy_gate_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && opcode_valid && opcode == 8'hF0 && !behavior_cfg_active[0] |-> !soft_reset)
		else $error("Legacy reset not gated.");

	pair_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
		clk_en && opcode_valid && opcode == 8'h66 ##1 clk_en && opcode_valid && opcode == 8'h99
		|-> soft_reset)
		else $error("Two step reset refused.");

	blank_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		erase_req && !behavior_cfg_active[5] |-> erase_start && !erase_skip)
		else $error("Erase not started with blank check off.");

	failed_erase_a: assert property (@(posedge clk) disable iff (!rst_n)
		erase_req && behavior_cfg_active[5] && !sector_erase_ok |-> erase_start)
		else $error("Failed sector not erased.");

	blank_skip_a: assert property (@(posedge clk) disable iff (!rst_n)
		erase_req && behavior_cfg_active[5] && sector_erase_ok && blank_read_done && !zero_found
		|-> erase_skip && !erase_start)
		else $error("Blank sector not skipped.");

endmodule // flash_command_behavior_config

// *** include/behavior_cfg_pkg.sv ***
// Package of constants and types for the command behaviour configuration bank.
// Overview of operation
// - Reload or soft reset loads active copy from stored copy.
// - Both copies read and written by host.
// - Stored bits flip from shipped state once.
// - Blank check on: failed sector erased unconditionally.
// - Good sector read; erase on zero, else skip.
// - Blank check covers parameter, sector, bulk erase.
// - Blank check off: erase always starts.
// - Wrap bit picks 256 or 512 byte wrap.
// - Bit three removes 4 kB parameter sectors.
// - Active sector bit read only from host.
// - Bit two selects resume or clear status.
// - Block erase size bit is ignored.
// - Bit zero gates legacy single byte reset.
// - Two step reset accepted whenever 99h directly follows 66h, whatever bit zero holds.
// - Bits seven and six read zero.
package behavior_cfg_pkg;

	// ------------------------------------------------------------
	// Register selection, fields and reset values
	// ------------------------------------------------------------
	localparam logic       SEL_STORED       = 1'b0;
	localparam logic       SEL_ACTIVE       = 1'b1;
	localparam int         BIT_BLANK_CHECK  = 5;
	localparam int         BIT_PAGE_WRAP    = 4;
	localparam int         BIT_PARAM_DIS    = 3;
	localparam int         BIT_RESUME_SEL   = 2;
	localparam int         BIT_BLOCK_SIZE   = 1;
	localparam int         BIT_LEGACY_RST   = 0;
	localparam logic [7:0] STORED_SHIPPED   = 8'h02;
	localparam logic [7:0] DEFINED_MASK     = 8'h3F;
	localparam logic [7:0] ACTIVE_RO_MASK   = 8'h08;
	localparam logic [7:0] OP_RESUME_CLR    = 8'h30;
	localparam logic [7:0] OP_LEGACY_RST    = 8'hF0;
	localparam logic [7:0] OP_RST_ENABLE    = 8'h66;
	localparam logic [7:0] OP_RST_EXECUTE   = 8'h99;
	localparam logic [8:0] WRAP_SHORT_MASK  = 9'h0FF;
	localparam logic [8:0] WRAP_LONG_MASK   = 9'h1FF;

	typedef struct packed {
		logic       write;
		logic       sel;
		logic [7:0] data;
	} reg_req_s;

	typedef struct packed {
		logic blank_check;
		logic page_wrap;
		logic param_sector_disable;
		logic resume_select;
		logic legacy_reset_enable;
	} controls_s;

	typedef enum logic [1:0] {
		ERASE_DIRECT,
		ERASE_BLANK_READ,
		ERASE_SKIP
	} erase_action_e;

endpackage

// *** tb/host_model.sv ***
// Host model that issues register accesses and instruction bytes.
module host_model
(
	input  wire logic                  clk,
	input  wire logic [7:0]            read_data,
	output logic                       req_valid,
	output behavior_cfg_pkg::reg_req_s req,
	output logic                       opcode_valid,
	output logic [7:0]                 opcode
);
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------
	// Requests
	// ------------------------------------------------------------
	initial
	begin
		req_valid = 1'b0;
		req = '0;
		opcode_valid = 1'b0;
		opcode = 8'h00;
	end
	// Data lines show the inverse once released, so stale values cannot match by luck.
	task automatic access(input logic wr, input logic sel, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{write: wr, sel: sel, data: d};
		@(posedge clk);
		req_valid <= 1'b0;
		req.data <= ~d;
		#1 q = read_data;
	endtask
	task automatic op(input logic [7:0] c);
		@(posedge clk);
		opcode_valid <= 1'b1;
		opcode <= c;
		#1;
	endtask
	task automatic op_end();
		@(posedge clk);
		opcode_valid <= 1'b0;
		opcode <= ~opcode;
	endtask
endmodule // host_model

// *** tb/tb_flash_command_behavior_config.sv ***
// Self-checking bench for the command behaviour configuration bank.
module tb_flash_command_behavior_config;
	timeunit 1ns;
	timeprecision 1ps;
	`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; \
		$display("[ERR] %0t %h %h", $time, a, b); end end
	logic                            clk, rst_n, reload, erase_req, ok, zf, brd, en;
	logic                            req_valid, opcode_valid, start, skip, is_res, is_clr, srst;
	logic [7:0]                      opcode, read_data, q, stored, active, d;
	logic [8:0]                      wrap;
	behavior_cfg_pkg::reg_req_s      req;
	behavior_cfg_pkg::erase_action_e act;
	behavior_cfg_pkg::controls_s     ctl;
	int                              failures, checks_done, cycles, seed;
	host_model host (.clk(clk), .read_data(read_data), .req_valid(req_valid), .req(req),
		.opcode_valid(opcode_valid), .opcode(opcode));
	flash_command_behavior_config DUT (.clk(clk), .rst_n(rst_n), .clk_en(en),
		.reload(reload), .req_valid(req_valid), .req(req), .read_data(read_data),
		.opcode_valid(opcode_valid), .opcode(opcode), .erase_req(erase_req),
		.sector_erase_ok(ok), .zero_found(zf), .blank_read_done(brd), .erase_action(act),
		.erase_start(start), .erase_skip(skip), .page_wrap_mask(wrap), .controls(ctl),
		.opcode_is_resume(is_res), .opcode_is_clear_status(is_clr), .soft_reset(srst));
	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Bit three of the active copy only follows the stored copy, so a write cannot move it.
	function automatic logic [7:0] masked(input logic [7:0] cur, input logic [7:0] v);
		return (v & 8'h37) | (cur & 8'h08);
	endfunction
	task automatic wr(input logic sel, input logic [7:0] v);
		host.access(1'b1, sel, v, q);
		if (sel)
			active = masked(active, v);
	endtask
	task automatic rd(input logic sel);
		host.access(1'b0, sel, 8'h00, q);
	endtask
	task automatic er(input logic [3:0] v, input logic [3:0] m, input logic [3:0] e);
		@(posedge clk);
		{erase_req, ok, zf, brd} <= v;
		#1 `CHK({act, start, skip} & m, e)
	endtask
	task automatic conclude();
		$display("failures=%0d checks_done=%0d", failures, checks_done);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			failures++;
			conclude();
		end
	end
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial
	begin
		seed = 32'hE25E;
		rst_n = 1'b0;
		{reload, erase_req, ok, zf, brd} = 5'h00;
		en = 1'b1;
		stored = 8'h02;
		active = 8'h02;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		rd(1'b0); `CHK(q, 8'h02)
		rd(1'b1); `CHK(q, 8'h02)
		wr(1'b1, 8'hFF); rd(1'b1); `CHK(q, 8'h37)
		host.op(8'h30); `CHK({is_res, is_clr}, 2'h2)
		host.op(8'hF0); `CHK(srst, 1'b1)
		host.op_end(); active = stored; rd(1'b1); `CHK(q, stored)
		host.op(8'hF0); `CHK(srst, 1'b0)
		host.op(8'h30); `CHK({is_res, is_clr}, 2'h1)
		host.op(8'h66); host.op(8'h99); `CHK(srst, 1'b1)
		host.op(8'h66); host.op(8'h00); host.op(8'h99); `CHK(srst, 1'b0)
		host.op_end();
		repeat (24)
		begin
			d = ($random(seed) & 8'hF7) | (stored & 8'h08);
			wr(1'b1, d); `CHK(wrap, d[4] ? 9'h1FF : 9'h0FF)
			`CHK(ctl.blank_check, d[5])
			`CHK(ctl.resume_select, d[2])
			`CHK(ctl.legacy_reset_enable, d[0])
			rd(1'b1); `CHK(q, active)
		end
		wr(1'b1, 8'h20);
		er(4'h8, 4'hF, 4'h2);
		er(4'hC, 4'hF, 4'h4);
		er(4'hE, 4'h3, 4'h2);
		er(4'hD, 4'h3, 4'h1);
		wr(1'b1, 8'h00);
		er(4'hC, 4'hF, 4'h2);
		wr(1'b0, 8'h2B); stored = 8'h2B; rd(1'b0); `CHK(q, 8'h2B)
		wr(1'b0, 8'h00); rd(1'b0); `CHK(q, 8'h2B)
		@(posedge clk);
		reload <= 1'b1;
		@(posedge clk);
		reload <= 1'b0;
		active = stored;
		#1 `CHK(ctl.param_sector_disable, 1'b1)
		rd(1'b1); `CHK(q, 8'h2B)
		wr(1'b1, 8'h00); rd(1'b1); `CHK(q, 8'h08)
		// A write while the clock enable is low must leave the active copy untouched.
		@(posedge clk);
		en <= 1'b0;
		host.access(1'b1, 1'b1, 8'h37, q);
		@(posedge clk);
		en <= 1'b1;
		rd(1'b1); `CHK(q, 8'h08)
		conclude();
	end
endmodule // tb_flash_command_behavior_config
